// ### hdl/csr_pkg.sv
package csr_pkg;

  // Register byte offsets
  localparam logic [7:0] CSR_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CSR_OFF_CFG    = 8'h04;
  localparam logic [7:0] CSR_OFF_INT    = 8'h08;
  localparam logic [7:0] CSR_OFF_PRST   = 8'h0C;

  // Control register upper bits
  localparam int CSR_CTRL_GUARD_BIT     = 19;
  localparam int CSR_CTRL_LOOP_EN_BIT   = 24;
  localparam int CSR_CTRL_LOCK_BIT      = 25;

  // Configuration register fields
  localparam int CSR_CFG_SEL_LSB        = 0;
  localparam int CSR_CFG_STS_LSB        = 2;
  localparam int CSR_CFG_SBUS_LSB       = 4;
  localparam int CSR_CFG_PBUS_LSB       = 8;
  localparam int CSR_CFG_CONV_BIT       = 14;
  localparam int CSR_CFG_LSRC_LSB       = 15;
  localparam int CSR_CFG_LPRE_BIT       = 17;
  localparam int CSR_CFG_LMUL_LSB       = 18;
  localparam int CSR_CFG_OSEL_LSB       = 24;
  localparam int CSR_CFG_ODIV_LSB       = 28;
  localparam int CSR_CFG_OHALF_BIT      = 31;

  // Interrupt register groups
  localparam int CSR_INT_FLAG_LSB       = 0;
  localparam int CSR_INT_FAIL_BIT       = 7;
  localparam int CSR_INT_EN_LSB         = 8;
  localparam int CSR_INT_CLR_LSB        = 16;
  localparam int CSR_INT_FAIL_CLR_BIT   = 23;
  localparam int CSR_NSRC               = 7;

  // Reset values and field masks
  localparam logic [31:0] CSR_CFG_RST   = 32'h0000_0000;
  localparam logic [31:0] CSR_INT_RST   = 32'h0000_0000;
  localparam logic [31:0] CSR_PRST_RST  = 32'h0000_0000;
  localparam logic [31:0] CSR_PRST_MASK = 32'h0047_00E1;
  localparam logic [31:0] CSR_CFG_MASK  = 32'hFF3F_C7F3;

  // Source codes
  localparam logic [1:0] CSR_SRC_FINT   = 2'h0;
  localparam logic [1:0] CSR_SRC_FEXT   = 2'h1;
  localparam logic [1:0] CSR_SRC_LOOP   = 2'h2;

  // Clock-output selector codes
  localparam logic [3:0] CSR_OUT_NONE   = 4'h0;
  localparam logic [3:0] CSR_OUT_LOOP   = 4'h7;

  // Wait cycles for a switch-time access
  localparam int CSR_SWITCH_WAIT        = 2;

  // AXI responses
  localparam logic [1:0] CSR_RESP_OKAY  = 2'h0;
  localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CSR_SW_IDLE = 3'b001,
    CSR_SW_WAIT = 3'b010,
    CSR_SW_DONE = 3'b100
  } csr_sw_t;

endpackage : csr_pkg

// ### hdl/csr_clock_select.sv
`timescale 1ns/1ps
module csr_clock_select
  import csr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  input  wire logic        s_axi_rvalid_unused,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Oscillator status and low-power pins, outside this clock domain
  input  wire logic [6:0]  osc_ready_pin,
  input  wire logic        loop_lock_pin,
  input  wire logic        ext_fail_pin,
  input  wire logic        low_power_entry,
  input  wire logic        low_power_wake,
  // Clock control outputs
  output logic             loop_enable,
  output logic [1:0]       system_source_status,
  output logic [3:0]       system_bus_divider,
  output logic [2:0]       peripheral_bus_divider,
  output logic [1:0]       loop_source_select,
  output logic [3:0]       loop_multiplier_factor,
  output logic [3:0]       clock_out_select,
  output logic [2:0]       clock_out_divider,
  output logic             clock_out_loop_halver,
  output logic             clock_guard_enable,
  output logic             fail_nmi
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [10:0] raw_in;
  assign raw_in = {low_power_wake, low_power_entry, ext_fail_pin,
                   loop_lock_pin, osc_ready_pin};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic [6:0] ready_s;
  logic       lock_s;
  logic       fail_s;
  logic       entry_s;
  logic       wake_s;
  assign ready_s = sync2_reg[6:0];
  assign lock_s  = sync2_reg[7];
  assign fail_s  = sync2_reg[8];
  assign entry_s = sync2_reg[9];
  assign wake_s  = sync2_reg[10];

  logic [6:0] ready_prev_reg;
  logic       fail_prev_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_prev_reg <= '0;
      fail_prev_reg  <= 1'b0;
    end else begin
      ready_prev_reg <= ready_s;
      fail_prev_reg  <= fail_s;
    end
  end
  logic [6:0] ready_rise;
  logic       fail_rise;
  assign ready_rise = ready_s & ~ready_prev_reg;
  assign fail_rise  = fail_s & ~fail_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data may arrive in either order
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        stall;
  logic        wr_fire;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid && !stall;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] csr_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : csr_merge

  function automatic logic csr_known(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a == CSR_OFF_CTRL) ok = 1'b1;
    else if (a == CSR_OFF_CFG) ok = 1'b1;
    else if (a == CSR_OFF_INT) ok = 1'b1;
    else if (a == CSR_OFF_PRST) ok = 1'b1;
    return ok;
  endfunction : csr_known

  logic [31:0] strb_mask;
  assign strb_mask = csr_merge(32'h0000_0000, 32'hFFFF_FFFF, w_strb_reg);

  logic wr_ctrl;
  logic wr_cfg;
  logic wr_int;
  logic wr_prst;
  assign wr_ctrl = wr_fire && aw_addr_reg == CSR_OFF_CTRL;
  assign wr_cfg  = wr_fire && aw_addr_reg == CSR_OFF_CFG;
  assign wr_int  = wr_fire && aw_addr_reg == CSR_OFF_INT;
  assign wr_prst = wr_fire && aw_addr_reg == CSR_OFF_PRST;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CSR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= csr_known(aw_addr_reg) ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register upper bits
  logic [1:0] system_source_select;
  logic sw_pending;
  logic loop_in_use;
  assign loop_in_use = system_source_status == CSR_SRC_LOOP ||
                       (sw_pending && system_source_select == CSR_SRC_LOOP);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_guard_enable <= 1'b0;
      loop_enable        <= 1'b0;
    end else begin
      if (wr_ctrl && strb_mask[CSR_CTRL_GUARD_BIT])
        clock_guard_enable <= w_data_reg[CSR_CTRL_GUARD_BIT];
      if (entry_s) begin
        loop_enable <= 1'b0;
      end else if (wr_ctrl && strb_mask[CSR_CTRL_LOOP_EN_BIT]) begin
        if (w_data_reg[CSR_CTRL_LOOP_EN_BIT] || !loop_in_use)
          loop_enable <= w_data_reg[CSR_CTRL_LOOP_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  logic        conv_bit_reg;
  logic        loop_prediv_reg;
  logic [31:0] cfg_new;
  logic        out_off;
  assign cfg_new = csr_merge(32'h0000_0000, w_data_reg, w_strb_reg);
  assign out_off = clock_out_select == CSR_OUT_NONE;
  logic fail_force;
  assign fail_force = clock_guard_enable && fail_rise &&
    (system_source_status == CSR_SRC_FEXT ||
     (system_source_status == CSR_SRC_LOOP &&
      loop_source_select == CSR_SRC_LOOP));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      system_source_select   <= CSR_SRC_FINT;
      system_bus_divider     <= '0;
      peripheral_bus_divider <= '0;
      conv_bit_reg           <= 1'b0;
      loop_source_select     <= '0;
      loop_prediv_reg        <= 1'b0;
      loop_multiplier_factor <= '0;
      clock_out_select       <= CSR_OUT_NONE;
      clock_out_divider      <= '0;
      clock_out_loop_halver  <= 1'b0;
    end else if (wake_s || fail_force) begin
      system_source_select <= CSR_SRC_FINT;
    end else if (wr_cfg) begin
      if (w_strb_reg[0]) begin
        system_source_select <= cfg_new[CSR_CFG_SEL_LSB +: 2];
        system_bus_divider   <= cfg_new[CSR_CFG_SBUS_LSB +: 4];
      end
      if (w_strb_reg[1]) begin
        peripheral_bus_divider <= cfg_new[CSR_CFG_PBUS_LSB +: 3];
        conv_bit_reg           <= cfg_new[CSR_CFG_CONV_BIT];
      end
      if (!loop_enable) begin
        if (w_strb_reg[1])
          loop_source_select[0] <= cfg_new[CSR_CFG_LSRC_LSB];
        if (w_strb_reg[2]) begin
          loop_source_select[1]  <= cfg_new[CSR_CFG_LSRC_LSB + 1];
          loop_prediv_reg        <= cfg_new[CSR_CFG_LPRE_BIT];
          loop_multiplier_factor <= cfg_new[CSR_CFG_LMUL_LSB +: 4];
        end
      end
      if (w_strb_reg[3]) begin
        clock_out_select <= cfg_new[CSR_CFG_OSEL_LSB +: 4];
        // Divider fields only move while the output pin is quiet
        if (out_off) begin
          clock_out_divider     <= cfg_new[CSR_CFG_ODIV_LSB +: 3];
          clock_out_loop_halver <= cfg_new[CSR_CFG_OHALF_BIT];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source switch: status follows a ready target, or, in CSR_SW_IDLE, drops to the internal source at once on wake or failure
  csr_sw_t     sw_state_reg;
  logic [1:0]  sw_wait_reg;
  logic        target_ready;
  always_comb begin
    target_ready = 1'b0;
    case (system_source_select)
      CSR_SRC_FINT: target_ready = ready_s[2];
      CSR_SRC_FEXT: target_ready = ready_s[3];
      CSR_SRC_LOOP: target_ready = lock_s && loop_enable;
      default:      target_ready = 1'b0;
    endcase
  end
  assign sw_pending = system_source_select != system_source_status &&
                      system_source_select != 2'h3;
  // Reserved select code leaves the running source in place
  assign stall = sw_state_reg == CSR_SW_WAIT;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_state_reg         <= CSR_SW_IDLE;
      sw_wait_reg          <= '0;
      system_source_status <= CSR_SRC_FINT;
    end else begin
      case (sw_state_reg)
        CSR_SW_IDLE: begin
          if (wake_s || fail_force) begin
            system_source_status <= CSR_SRC_FINT;
          end else if (sw_pending && target_ready) begin
            sw_state_reg <= CSR_SW_WAIT;
            sw_wait_reg  <= 2'(CSR_SWITCH_WAIT - 1);
          end
        end
        CSR_SW_WAIT: begin
          if (sw_wait_reg == 2'h0) begin
            system_source_status <= system_source_select;
            sw_state_reg         <= CSR_SW_DONE;
          end else begin
            sw_wait_reg <= sw_wait_reg - 2'h1;
          end
        end
        CSR_SW_DONE: sw_state_reg <= CSR_SW_IDLE;
        default:     sw_state_reg <= CSR_SW_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags, enables and peripheral reset register
  logic [6:0]  ready_flag_reg;
  logic [6:0]  ready_irq_on_reg;
  logic        clock_failure_flag;
  logic [31:0] prst_reg;
  logic [6:0]  clr_vec;
  assign clr_vec = (wr_int && w_strb_reg[2]) ?
                   w_data_reg[CSR_INT_CLR_LSB +: CSR_NSRC] : 7'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_flag_reg     <= '0;
      ready_irq_on_reg   <= '0;
      clock_failure_flag <= 1'b0;
      prst_reg           <= CSR_PRST_RST;
    end else begin
      // Set beats a clear that lands in the same cycle
      ready_flag_reg <= (ready_flag_reg & ~clr_vec) |
                        (ready_rise & ready_irq_on_reg);
      if (wr_int && w_strb_reg[1])
        ready_irq_on_reg <= w_data_reg[CSR_INT_EN_LSB +: CSR_NSRC];
      if (clock_guard_enable && fail_rise)
        clock_failure_flag <= 1'b1;
      else if (wr_int && w_strb_reg[2] && w_data_reg[CSR_INT_FAIL_CLR_BIT])
        clock_failure_flag <= 1'b0;
      if (wr_prst)
        prst_reg <= csr_merge(prst_reg, w_data_reg, w_strb_reg) &
                    CSR_PRST_MASK;
    end
  end

  assign fail_nmi = clock_failure_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel; held off while a source switch is in flight
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == CSR_OFF_CTRL) begin
      rd_val[CSR_CTRL_GUARD_BIT]   = clock_guard_enable;
      rd_val[CSR_CTRL_LOOP_EN_BIT] = loop_enable;
      rd_val[CSR_CTRL_LOCK_BIT]    = lock_s;
    end else if (s_axi_araddr == CSR_OFF_CFG) begin
      rd_val[CSR_CFG_SEL_LSB +: 2]  = system_source_select;
      rd_val[CSR_CFG_STS_LSB +: 2]  = system_source_status;
      rd_val[CSR_CFG_SBUS_LSB +: 4] = system_bus_divider;
      rd_val[CSR_CFG_PBUS_LSB +: 3] = peripheral_bus_divider;
      rd_val[CSR_CFG_CONV_BIT]      = conv_bit_reg;
      rd_val[CSR_CFG_LSRC_LSB +: 2] = loop_source_select;
      rd_val[CSR_CFG_LPRE_BIT]      = loop_prediv_reg;
      rd_val[CSR_CFG_LMUL_LSB +: 4] = loop_multiplier_factor;
      rd_val[CSR_CFG_OSEL_LSB +: 4] = clock_out_select;
      rd_val[CSR_CFG_ODIV_LSB +: 3] = clock_out_divider;
      rd_val[CSR_CFG_OHALF_BIT]     = clock_out_loop_halver;
    end else if (s_axi_araddr == CSR_OFF_INT) begin
      rd_val[CSR_INT_FLAG_LSB +: CSR_NSRC] = ready_flag_reg;
      rd_val[CSR_INT_FAIL_BIT]             = clock_failure_flag;
      rd_val[CSR_INT_EN_LSB +: CSR_NSRC]   = ready_irq_on_reg;
    end else if (s_axi_araddr == CSR_OFF_PRST) begin
      rd_val = prst_reg;
    end
  end

  assign s_axi_arready = !s_axi_rvalid && !stall;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= CSR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= csr_known(s_axi_araddr) ? CSR_RESP_OKAY
                                              : CSR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : csr_clock_select

// ### testbench/csr_clock_select_asserts.sv
`timescale 1ns/1ps
module csr_clock_select_asserts
  import csr_pkg::*;
(
  // Watched ports
  input wire logic        clk, rst_b, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_rvalid, s_axi_rready, s_axi_arvalid,
  input wire logic        s_axi_arready, ext_fail_pin, low_power_entry,
  input wire logic        low_power_wake, loop_enable, fail_nmi,
  input wire logic        clock_out_loop_halver, clock_guard_enable,
  input wire logic [1:0]  s_axi_bresp, system_source_status,
  input wire logic [1:0]  loop_source_select,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0]  loop_multiplier_factor, clock_out_select,
  input wire logic [2:0]  clock_out_divider
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  a_read_no_wait: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_status_valid: assert property (
    system_source_status != 2'h3)
    else $error("status code reserved");
  a_loop_ready_first: assert property (
    $changed(system_source_status) && system_source_status == CSR_SRC_LOOP
    |-> loop_enable)
    else $error("switched to loop while off");
  a_wake_forces: assert property (
    $rose(low_power_wake) |-> ##[1:4] system_source_status == CSR_SRC_FINT)
    else $error("wake kept source");
  a_entry_clears: assert property (
    $rose(low_power_entry) |-> ##[1:4] !loop_enable)
    else $error("loop enable kept on entry");
  a_loop_fields_lock: assert property (
    loop_enable && $past(loop_enable)
    |-> $stable(loop_source_select) && $stable(loop_multiplier_factor))
    else $error("loop field changed while on");
  // Select may change with the divider in one write; only the old value counts
  a_out_fields_lock: assert property (
    clock_out_select != 4'h0 && $past(clock_out_select) != 4'h0
    |-> $stable(clock_out_divider) && $stable(clock_out_loop_halver))
    else $error("output divider changed while on");
  a_fail_cause: assert property (
    $rose(fail_nmi) |-> ext_fail_pin && clock_guard_enable)
    else $error("failure flag without cause");
  c_loop_used: cover property (system_source_status == CSR_SRC_LOOP);
  c_fail_seen: cover property ($rose(fail_nmi));
  c_wake_seen: cover property ($rose(low_power_wake));
endmodule : csr_clock_select_asserts

bind csr_clock_select csr_clock_select_asserts csr_clock_select_asserts_i (.*);

// ### testbench/tb_csr_clock_select.sv
`timescale 1ns/1ps
module tb_csr_clock_select;
  import csr_pkg::*;
  logic        clk = '0, rst_b = '0, s_axi_rvalid_unused = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, loop_lock_pin = '0;
  logic        ext_fail_pin = '0, low_power_entry = '0, low_power_wake = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv, d;
  logic [31:0] seed = 32'h0000_003E;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [6:0]  osc_ready_pin = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, loop_enable, clock_out_loop_halver, fail_nmi;
  logic        clock_guard_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, system_source_status, resp;
  logic [1:0]  loop_source_select;
  logic [3:0]  system_bus_divider, loop_multiplier_factor, clock_out_select;
  logic [2:0]  peripheral_bus_divider, clock_out_divider;
  int          fails = 0, tests_run = 0, n;

  csr_clock_select csr_clock_select_i (.*);

  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Status bits are hardware owned, so they never echo what was written
  function automatic logic [31:0] cfg_exp(input logic [31:0] v);
    return v & CSR_CFG_MASK & ~32'h0000_000C;
  endfunction : cfg_exp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (s_axi_bvalid !== 1'b1 && k < 99);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 99) fails++;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 99);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 99) fails++;
    @(posedge clk);
  endtask : rd

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails++;
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(CSR_OFF_CFG);
    chk(rdv, CSR_CFG_RST);
    rd(CSR_OFF_INT);
    chk(rdv, CSR_INT_RST);
    rd(CSR_OFF_PRST);
    chk(rdv, CSR_PRST_RST);
    rd(8'h40);
    chk(resp, CSR_RESP_SLVERR);
    chk(rdv, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    chk(resp, CSR_RESP_SLVERR);
    $display("reset and map done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hF0FF_FFFC : rnd() & 32'hF0FF_FFFC;
      // No prefetch buffer in this block, dividers are only stored
      wr(CSR_OFF_CFG, d);
      rd(CSR_OFF_CFG);
      chk(rdv, cfg_exp(d));
      chk({clock_out_loop_halver, clock_out_divider, loop_multiplier_factor,
           loop_source_select, peripheral_bus_divider, system_bus_divider},
          {d[31:28], d[21:18], d[16:15], d[10:8], d[7:4]});
      wr(CSR_OFF_PRST, d);
      rd(CSR_OFF_PRST);
      chk(rdv, d & CSR_PRST_MASK);
    end
    wr(CSR_OFF_CFG, 32'h0300_0000);
    wr(CSR_OFF_CFG, 32'hD300_0000);
    rd(CSR_OFF_CFG);
    chk(rdv, 32'h0300_0000);
    chk(clock_out_select, 4'h3);
    wr(CSR_OFF_CFG, 32'h0);
    $display("config fields done");
    loop_lock_pin <= 1'b1;
    wr(CSR_OFF_CTRL, 32'h0100_0000);
    repeat (4) @(posedge clk);
    rd(CSR_OFF_CTRL);
    chk(rdv & 32'h0308_0000, 32'h0300_0000);
    // Loop fields in this write are ignored while loop_enable is on; only the select moves to the loop
    wr(CSR_OFF_CFG, 32'h0014_0002);
    n = 0;
    while (system_source_status !== CSR_SRC_LOOP && n < 20) begin
      @(posedge clk);
      n++;
    end
    rd(CSR_OFF_CFG);
    chk(rdv, 32'h0000_000A);
    chk(system_source_status, CSR_SRC_LOOP);
    wr(CSR_OFF_CTRL, 32'h0);
    chk(loop_enable, 1'b1);
    low_power_wake <= 1'b1;
    repeat (5) @(posedge clk);
    low_power_wake <= 1'b0;
    rd(CSR_OFF_CFG);
    chk(rdv, 32'h0);
    low_power_entry <= 1'b1;
    repeat (5) @(posedge clk);
    low_power_entry <= 1'b0;
    chk(loop_enable, 1'b0);
    $display("loop switch done");
    osc_ready_pin <= 7'h01;
    repeat (5) @(posedge clk);
    osc_ready_pin <= 7'h00;
    wr(CSR_OFF_INT, 32'h0000_7F00);
    rd(CSR_OFF_INT);
    chk(rdv, 32'h0000_7F00);
    osc_ready_pin <= 7'h7F;
    repeat (5) @(posedge clk);
    wr(CSR_OFF_INT, 32'h0000_7F00);
    rd(CSR_OFF_INT);
    chk(rdv, 32'h0000_7F7F);
    wr(CSR_OFF_INT, 32'h007F_7F00);
    rd(CSR_OFF_INT);
    chk(rdv, 32'h0000_7F00);
    $display("ready flags done");
    ext_fail_pin <= 1'b1;
    repeat (5) @(posedge clk);
    ext_fail_pin <= 1'b0;
    chk(fail_nmi, 1'b0);
    wr(CSR_OFF_CTRL, 32'h0008_0000);
    chk(clock_guard_enable, 1'b1);
    ext_fail_pin <= 1'b1;
    repeat (5) @(posedge clk);
    rd(CSR_OFF_INT);
    chk({fail_nmi, rdv[7]}, 2'h3);
    wr(CSR_OFF_INT, 32'h0080_0000);
    chk(fail_nmi, 1'b0);
    $display("failure flag done");
    give_verdict;
  end
endmodule : tb_csr_clock_select
